/* testbench/alx_exec_bench.sv */
`timescale 1ns/10ps
module alx_exec_bench;
    logic i_ref_clk, i_reset, i_clk_en, i_issue, i_wdt_tick, i_wake;
    alx_pkg::alx_op_t i_op, op;
    logic [7:0] i_mem_addr, i_mem_rdata, i_imm, ra;
    logic [2:0] i_bit_sel;
    logic [11:0] i_target, o_pc;
    logic o_busy, o_mem_we, o_signed_overflow_flag, o_zero_flag, o_nibble_carry_flag;
    logic o_carry_flag, o_powerdown_flag, o_watchdog_timeout_flag, o_halted, o_stack_overflow;
    logic [7:0] o_mem_addr, o_mem_wdata, o_accumulator_reg, o_watchdog_counter;
    int acc, pc, wdt, wd, wa, calls, miscompares, cmp_count;
    logic m_c, m_ac, m_ov, m_z, m_pdf, m_to, m_hlt, m_bz, m_we, m_sov, r1, r2, skip;
    alx_exec u_alx_exec (.i_ref_clk, .i_reset, .i_clk_en, .i_issue, .i_op, .i_mem_addr,
        .i_mem_rdata, .i_imm, .i_bit_sel, .i_target, .i_wdt_tick, .i_wake, .o_busy, .o_mem_we,
        .o_mem_addr, .o_mem_wdata, .o_accumulator_reg, .o_pc, .o_signed_overflow_flag,
        .o_zero_flag, .o_nibble_carry_flag, .o_carry_flag, .o_powerdown_flag,
        .o_watchdog_timeout_flag, .o_watchdog_counter, .o_halted, .o_stack_overflow);
    // ********************
    // Reference model
    // ********************
    function automatic logic [7:0] rb();
        return 8'($urandom());
    endfunction
    task chk(input logic [23:0] g, input logic [23:0] e);
        cmp_count++;
        if (g !== e) begin
            miscompares++;
            $display("wrong value at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    task cmp_all;
        chk(24'({o_signed_overflow_flag, o_zero_flag, o_nibble_carry_flag, o_carry_flag,
            o_powerdown_flag, o_watchdog_timeout_flag, o_halted, o_busy, o_accumulator_reg}),
            24'({m_ov, m_z, m_ac, m_c, m_pdf, m_to, m_hlt, m_bz | m_hlt, acc[7:0]}));
        if (!skip) chk(24'(o_pc), 24'(pc[11:0]));
        if (m_we) chk({7'h00, o_mem_we, o_mem_addr, o_mem_wdata}, {8'h01, wa[7:0], wd[7:0]});
        else chk(24'(o_mem_we), 24'h0);
        chk(24'({o_stack_overflow, o_watchdog_counter}), 24'({m_sov, wdt[7:0]}));
    endtask
    task model(input alx_pkg::alx_op_t o, input logic [7:0] ad, m, x);
        int a, s, k, r, lo, hi, c1;
        logic dst;
        a = acc;
        s = (o inside {alx_pkg::ALX_OP_ADD_AX, alx_pkg::ALX_OP_AND_AX}) ? x : m;
        k = (o inside {alx_pkg::ALX_OP_ADC_A, alx_pkg::ALX_OP_ADC_M}) ? m_c : 0;
        r = 0;
        m_we = 1'b0;
        m_bz = 1'b0;
        pc = pc + 1;
        case (o)
            alx_pkg::ALX_OP_ADC_A, alx_pkg::ALX_OP_ADC_M, alx_pkg::ALX_OP_ADD_A,
            alx_pkg::ALX_OP_ADD_AX, alx_pkg::ALX_OP_ADD_M: begin
                r = a + s + k;
                m_ov = a[7] == s[7] && r[7] != a[7];
                m_ac = (a % 16 + s % 16 + k) > 15;
                m_c = r > 255;
            end
            alx_pkg::ALX_OP_AND_A, alx_pkg::ALX_OP_AND_AX, alx_pkg::ALX_OP_AND_M: r = a & s;
            alx_pkg::ALX_OP_CALL, alx_pkg::ALX_OP_JMP: begin
                pc = i_target;
                m_bz = 1'b1;
                skip = 1'b0;
                if (o == alx_pkg::ALX_OP_CALL && ++calls > alx_pkg::ALX_STACK_DEPTH) m_sov = 1'b1;
            end
            alx_pkg::ALX_OP_CLR_BIT: r = m & ~(1 << i_bit_sel);
            alx_pkg::ALX_OP_WDT_CLR: begin
                {m_pdf, m_to, r1, r2} = 4'h0;
                wdt = 0;
            end
            alx_pkg::ALX_OP_WDT_PRE1: r1 = 1'b1;
            alx_pkg::ALX_OP_WDT_PRE2: r2 = 1'b1;
            alx_pkg::ALX_OP_CPL_M, alx_pkg::ALX_OP_CPL_A: r = ~m;
            alx_pkg::ALX_OP_DAA: begin
                lo = a % 16;
                hi = a / 16;
                c1 = 0;
                if (lo > 9 || m_ac) begin
                    lo = lo + 6;
                    c1 = !m_ac;
                end
                if (hi + c1 > 9 || m_c) begin
                    hi = hi + 6 + c1;
                    m_c = 1'b1;
                end
                else hi = hi + c1;
                r = (hi % 16) * 16 + lo % 16;
            end
            alx_pkg::ALX_OP_DEC_M, alx_pkg::ALX_OP_DEC_A: r = m - 1;
            alx_pkg::ALX_OP_INC_M, alx_pkg::ALX_OP_INC_A: r = m + 1;
            alx_pkg::ALX_OP_HALT: begin
                {m_pdf, m_to, m_hlt} = 3'b101;
                wdt = 0;
            end
            default: r = 0;
        endcase
        if (r1 && r2) begin
            {m_pdf, m_to, r1, r2} = 4'h0;
            wdt = 0;
        end
        m_we = o inside {alx_pkg::ALX_OP_ADC_M, alx_pkg::ALX_OP_ADD_M, alx_pkg::ALX_OP_AND_M,
            alx_pkg::ALX_OP_CLR_M, alx_pkg::ALX_OP_CLR_BIT, alx_pkg::ALX_OP_CPL_M,
            alx_pkg::ALX_OP_DAA, alx_pkg::ALX_OP_DEC_M, alx_pkg::ALX_OP_INC_M};
        dst = o inside {alx_pkg::ALX_OP_ADC_A, alx_pkg::ALX_OP_ADD_A, alx_pkg::ALX_OP_ADD_AX,
            alx_pkg::ALX_OP_AND_A, alx_pkg::ALX_OP_AND_AX, alx_pkg::ALX_OP_CPL_A,
            alx_pkg::ALX_OP_DEC_A, alx_pkg::ALX_OP_INC_A};
        if (dst) acc = r & 255;
        wd = r & 255;
        wa = ad;
        if ((m_we || dst) && !(o inside {alx_pkg::ALX_OP_CLR_BIT, alx_pkg::ALX_OP_DAA,
            alx_pkg::ALX_OP_CLR_M})) begin
            m_z = (r & 255) == 0;
        end
        // Writing the low pc byte moves pc out of model reach until a jump
        if (m_we && ad == alx_pkg::ALX_PCL_ADDR) begin
            m_bz = 1'b1;
            skip = 1'b1;
        end
    endtask
    // ********************
    // Drivers
    // ********************
    task summarize;
        $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) begin
            $display("Test passed");
        end
        else begin
            $display("Test failed");
        end
        $finish;
    endtask
    task wake;
        int n;
        i_wake = 1'b1;
        n = 0;
        do begin
            @(negedge i_ref_clk);
            n++;
        end while (o_halted !== 1'b0 && n < 8);
        i_wake = 1'b0;
        {m_hlt, m_bz} = 2'b00;
        if (n == 8) begin
            miscompares++;
            summarize;
        end
        cmp_all;
    endtask
    task run(input alx_pkg::alx_op_t o, input logic [7:0] ad, m, x);
        @(negedge i_ref_clk);
        {i_op, i_mem_addr, i_mem_rdata, i_imm} = {o, ad, m, x};
        i_bit_sel = 3'($urandom());
        i_target = 12'($urandom());
        i_issue = 1'b1;
        model(o, ad, m, x);
        @(negedge i_ref_clk);
        i_issue = 1'b0;
        cmp_all;
        if (m_bz && !m_hlt) begin
            // Issue into the stall cycle; it has to be dropped
            i_op = alx_pkg::ALX_OP_INC_A;
            i_issue = 1'b1;
            @(negedge i_ref_clk);
            i_issue = 1'b0;
            {m_bz, m_we} = 2'b00;
            cmp_all;
        end
        if (m_hlt) wake;
    endtask
    task tick(input int n);
        @(negedge i_ref_clk);
        i_wdt_tick = 1'b1;
        repeat (n) @(negedge i_ref_clk);
        i_wdt_tick = 1'b0;
        wdt = wdt + n;
        if (wdt > 255) m_to = 1'b1;
        wdt = wdt % 256;
        cmp_all;
    endtask
    initial begin
        i_ref_clk = 1'b0;
        forever #2 i_ref_clk = ~i_ref_clk;
    end
    initial begin
        void'($urandom(32'hbcbe));
        {i_reset, i_clk_en, i_issue, i_wdt_tick, i_wake} = 5'b11000;
        {i_mem_addr, i_mem_rdata, i_imm, i_bit_sel, i_target} = '0;
        i_op = alx_pkg::ALX_OP_NONE;
        {m_c, m_ac, m_ov, m_z, m_pdf, m_to, m_hlt, m_bz, m_we, m_sov, r1, r2, skip} = '0;
        repeat (2) @(negedge i_ref_clk);
        i_reset = 1'b0;
        run(alx_pkg::ALX_OP_ADD_M, alx_pkg::ALX_PCL_ADDR, 8'h11, 8'h00);
        run(alx_pkg::ALX_OP_JMP, 8'h10, 8'h00, 8'h00);
        $display("test stall done");
        run(alx_pkg::ALX_OP_HALT, 8'h10, 8'h00, 8'h00);
        run(alx_pkg::ALX_OP_WDT_PRE1, 8'h10, 8'h00, 8'h00);
        run(alx_pkg::ALX_OP_WDT_PRE2, 8'h10, 8'h00, 8'h00);
        tick(256);
        tick(3);
        run(alx_pkg::ALX_OP_WDT_CLR, 8'h10, 8'h00, 8'h00);
        $display("test watchdog done");
        repeat (7) run(alx_pkg::ALX_OP_CALL, 8'h10, 8'h00, 8'h00);
        @(negedge i_ref_clk);
        {i_clk_en, i_op, i_imm, i_issue} = {1'b0, alx_pkg::ALX_OP_ADD_AX, 8'h55, 1'b1};
        @(negedge i_ref_clk);
        {i_clk_en, i_issue} = 2'b10;
        cmp_all;
        $display("test call and freeze done");
        for (int i = 1; i < 24; i++) run(alx_pkg::alx_op_t'(i), 8'h20, rb(), rb());
        $display("test each operation done");
        repeat (400) begin
            op = alx_pkg::alx_op_t'(1 + $urandom() % 23);
            if (op inside {alx_pkg::ALX_OP_WDT_PRE1, alx_pkg::ALX_OP_WDT_PRE2}) begin
                op = alx_pkg::ALX_OP_ADC_M;
            end
            ra = rb();
            if (ra == alx_pkg::ALX_PCL_ADDR) ra = 8'h07;
            run(op, ra, rb(), rb());
        end
        $display("test random done");
        summarize;
    end
endmodule
bind alx_exec alx_exec_props #(.PC_W(PC_W)) u_alx_exec_props (.i_ref_clk, .i_reset, .i_clk_en,
    .i_issue, .i_op, .i_mem_addr, .i_mem_rdata, .i_target, .o_busy, .o_mem_we, .o_mem_addr,
    .o_mem_wdata, .o_accumulator_reg, .o_pc, .o_signed_overflow_flag, .o_zero_flag,
    .o_nibble_carry_flag, .o_carry_flag, .o_powerdown_flag, .o_watchdog_timeout_flag,
    .o_watchdog_counter, .o_halted);

/* testbench/alx_exec_props.sv */
`timescale 1ns/10ps
// ********************
// Execution checker
// ********************
module alx_exec_props #(
    parameter int PC_W = alx_pkg::ALX_PC_W
) (
    // Clock and issue
    input wire logic i_ref_clk,
    input wire logic i_reset,
    input wire logic i_clk_en,
    input wire logic i_issue,
    input wire alx_pkg::alx_op_t i_op,
    input wire logic [7:0] i_mem_addr,
    input wire logic [7:0] i_mem_rdata,
    input wire logic [PC_W-1:0] i_target,
    // Results
    input wire logic o_busy,
    input wire logic o_mem_we,
    input wire logic [7:0] o_mem_addr,
    input wire logic [7:0] o_mem_wdata,
    input wire logic [7:0] o_accumulator_reg,
    input wire logic [PC_W-1:0] o_pc,
    input wire logic o_signed_overflow_flag,
    input wire logic o_zero_flag,
    input wire logic o_nibble_carry_flag,
    input wire logic o_carry_flag,
    input wire logic o_powerdown_flag,
    input wire logic o_watchdog_timeout_flag,
    input wire logic [7:0] o_watchdog_counter,
    input wire logic o_halted
);
    logic tk;
    logic [7:0] sum_r;
    assign tk = i_clk_en && i_issue && !o_busy;
    // Sum without carry, so a leaking carry shows
    always_ff @(posedge i_ref_clk) begin
        sum_r <= o_accumulator_reg + i_mem_rdata;
    end
    default clocking cb @(posedge i_ref_clk);
    endclocking
    default disable iff (i_reset);
    chk_add_nocarry:
    assert property (tk && i_op == alx_pkg::ALX_OP_ADD_A |=> o_accumulator_reg == sum_r)
        else $error("add result wrong");
    chk_and_keeps:
    assert property (tk && i_op == alx_pkg::ALX_OP_AND_A |=>
        $stable({o_signed_overflow_flag, o_nibble_carry_flag, o_carry_flag}))
        else $error("and changed flags");
    chk_jump_stall:
    assert property (tk && i_op == alx_pkg::ALX_OP_JMP |=> o_pc == $past(i_target) && o_busy)
        else $error("jump target wrong");
    chk_clear_byte:
    assert property (tk && i_op == alx_pkg::ALX_OP_CLR_M |=> o_mem_we && o_mem_wdata == 8'h00
        && o_mem_addr == $past(i_mem_addr) && $stable({o_zero_flag, o_carry_flag}))
        else $error("byte clear wrong");
    chk_halt_entry:
    assert property (tk && i_op == alx_pkg::ALX_OP_HALT |=> o_halted && o_powerdown_flag
        && !o_watchdog_timeout_flag && o_watchdog_counter == 8'h00)
        else $error("halt entry wrong");
    chk_wdt_clear:
    assert property (tk && i_op == alx_pkg::ALX_OP_WDT_CLR |=> !o_powerdown_flag
        && !o_watchdog_timeout_flag && o_watchdog_counter == 8'h00)
        else $error("watchdog clear wrong");
    chk_inc_mem:
    assert property (tk && i_op == alx_pkg::ALX_OP_INC_M |=> o_mem_we
        && o_mem_wdata == $past(i_mem_rdata) + 8'h01 && o_zero_flag == (o_mem_wdata == 8'h00))
        else $error("increment wrong");
    chk_invert_acc:
    assert property (tk && i_op == alx_pkg::ALX_OP_CPL_A |=> !o_mem_we
        && o_accumulator_reg == ~$past(i_mem_rdata) && $stable(o_carry_flag))
        else $error("invert to acc wrong");
    chk_daa_flags:
    assert property (tk && i_op == alx_pkg::ALX_OP_DAA |=> o_mem_we
        && $stable({o_signed_overflow_flag, o_zero_flag, o_nibble_carry_flag}))
        else $error("decimal adjust flags wrong");
endmodule

/* verilog/alx_exec.sv */
`timescale 1ns/10ps
module alx_exec #(
    parameter int DATA_W = alx_pkg::ALX_DATA_W,
    parameter int PC_W = alx_pkg::ALX_PC_W,
    parameter int WDT_W = alx_pkg::ALX_WDT_W,
    parameter int STACK_DEPTH = alx_pkg::ALX_STACK_DEPTH
) (
    // Clock and reset
    input wire logic i_ref_clk,
    input wire logic i_reset,
    input wire logic i_clk_en,
    // Instruction issue
    input wire logic i_issue,
    input wire alx_pkg::alx_op_t i_op,
    input wire logic [7:0] i_mem_addr,
    input wire logic [7:0] i_mem_rdata,
    input wire logic [7:0] i_imm,
    input wire logic [2:0] i_bit_sel,
    input wire logic [PC_W-1:0] i_target,
    input wire logic i_wdt_tick,
    input wire logic i_wake,
    // Results
    output logic o_busy,
    output logic o_mem_we,
    output logic [7:0] o_mem_addr,
    output logic [7:0] o_mem_wdata,
    output logic [7:0] o_accumulator_reg,
    output logic [PC_W-1:0] o_pc,
    output logic o_signed_overflow_flag,
    output logic o_zero_flag,
    output logic o_nibble_carry_flag,
    output logic o_carry_flag,
    output logic o_powerdown_flag,
    output logic o_watchdog_timeout_flag,
    output logic [WDT_W-1:0] o_watchdog_counter,
    output logic o_halted,
    output logic o_stack_overflow
);

    // ****************************************
    // Arithmetic helpers
    // ****************************************
    typedef struct packed {
        logic [7:0] sum;
        logic c;
        logic ac;
        logic ov;
    } alx_add_t;

    function automatic alx_add_t alx_add(input logic [7:0] a, input logic [7:0] b,
                                         input logic cin);
        alx_add_t r;
        logic [4:0] lo;
        logic [8:0] full;
        lo = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
        full = {1'b0, a} + {1'b0, b} + {8'h00, cin};
        r.sum = full[7:0];
        r.c = full[8];
        r.ac = lo[4];
        r.ov = (a[7] == b[7]) && (full[7] != a[7]);
        return r;
    endfunction

    // ****************************************
    // State
    // ****************************************
    logic [7:0] acc_r;
    logic [PC_W-1:0] pc_r;
    logic ov_r, z_r, ac_r, c_r, pdf_r, to_r;
    logic [WDT_W-1:0] wdt_r;
    logic pre1_r, pre2_r;
    logic halted_r;
    logic [1:0] stall_r;
    logic [PC_W-1:0] stack_r [STACK_DEPTH];
    logic [2:0] sp_r;
    logic full_r;
    logic ovf_r;
    logic we_r;
    logic [7:0] waddr_r, wdata_r;

    // ****************************************
    // Combinational datapath
    // ****************************************
    alx_add_t add_res;
    logic [7:0] res;
    logic to_acc, to_mem, upd_arith, upd_z;
    logic [3:0] daa_lo, daa_hi;
    logic daa_ac1, daa_c;
    logic [4:0] hi_sum;
    logic go;

    localparam logic [7:0] ALX_ZERO = alx_pkg::ALX_ZERO_BYTE;

    assign go = i_clk_en && i_issue && !halted_r && (stall_r == 2'd0);

    always_comb begin
        add_res = alx_add(acc_r, i_mem_rdata, 1'b0);
        res = ALX_ZERO;
        to_acc = 1'b0;
        to_mem = 1'b0;
        upd_arith = 1'b0;
        upd_z = 1'b0;
        // Decimal adjust, computed from the accumulator
        if (acc_r[3:0] > alx_pkg::ALX_BCD_LIMIT || ac_r) begin
            daa_lo = acc_r[3:0] + alx_pkg::ALX_BCD_ADJ;
            daa_ac1 = !ac_r;
        end else begin
            daa_lo = acc_r[3:0];
            daa_ac1 = 1'b0;
        end
        hi_sum = {1'b0, acc_r[7:4]} + {4'h0, daa_ac1};
        if (hi_sum > {1'b0, alx_pkg::ALX_BCD_LIMIT} || c_r) begin
            daa_hi = hi_sum[3:0] + alx_pkg::ALX_BCD_ADJ;
            daa_c = 1'b1;
        end else begin
            daa_hi = hi_sum[3:0];
            daa_c = c_r;
        end
        unique case (i_op)
            alx_pkg::ALX_OP_ADC_A: begin
                add_res = alx_add(acc_r, i_mem_rdata, c_r);
                res = add_res.sum;
                to_acc = 1'b1;
                upd_arith = 1'b1;
            end
            alx_pkg::ALX_OP_ADC_M: begin
                add_res = alx_add(acc_r, i_mem_rdata, c_r);
                res = add_res.sum;
                to_mem = 1'b1;
                upd_arith = 1'b1;
            end
            alx_pkg::ALX_OP_ADD_A: begin
                res = add_res.sum;
                to_acc = 1'b1;
                upd_arith = 1'b1;
            end
            alx_pkg::ALX_OP_ADD_AX: begin
                add_res = alx_add(acc_r, i_imm, 1'b0);
                res = add_res.sum;
                to_acc = 1'b1;
                upd_arith = 1'b1;
            end
            alx_pkg::ALX_OP_ADD_M: begin
                res = add_res.sum;
                to_mem = 1'b1;
                upd_arith = 1'b1;
            end
            alx_pkg::ALX_OP_AND_A: begin
                res = acc_r & i_mem_rdata;
                to_acc = 1'b1;
                upd_z = 1'b1;
            end
            alx_pkg::ALX_OP_AND_AX: begin
                res = acc_r & i_imm;
                to_acc = 1'b1;
                upd_z = 1'b1;
            end
            alx_pkg::ALX_OP_AND_M: begin
                res = acc_r & i_mem_rdata;
                to_mem = 1'b1;
                upd_z = 1'b1;
            end
            alx_pkg::ALX_OP_CLR_M: begin
                res = ALX_ZERO;
                to_mem = 1'b1;
            end
            alx_pkg::ALX_OP_CLR_BIT: begin
                res = i_mem_rdata & ~(alx_pkg::ALX_ONE_BYTE << i_bit_sel);
                to_mem = 1'b1;
            end
            alx_pkg::ALX_OP_CPL_M: begin
                res = ~i_mem_rdata;
                to_mem = 1'b1;
                upd_z = 1'b1;
            end
            alx_pkg::ALX_OP_CPL_A: begin
                res = ~i_mem_rdata;
                to_acc = 1'b1;
                upd_z = 1'b1;
            end
            alx_pkg::ALX_OP_DAA: begin
                res = {daa_hi, daa_lo};
                to_mem = 1'b1;
            end
            alx_pkg::ALX_OP_DEC_M, alx_pkg::ALX_OP_DEC_A: begin
                res = i_mem_rdata - alx_pkg::ALX_ONE_BYTE;
                to_mem = (i_op == alx_pkg::ALX_OP_DEC_M);
                to_acc = (i_op == alx_pkg::ALX_OP_DEC_A);
                upd_z = 1'b1;
            end
            alx_pkg::ALX_OP_INC_M, alx_pkg::ALX_OP_INC_A: begin
                res = i_mem_rdata + alx_pkg::ALX_ONE_BYTE;
                to_mem = (i_op == alx_pkg::ALX_OP_INC_M);
                to_acc = (i_op == alx_pkg::ALX_OP_INC_A);
                upd_z = 1'b1;
            end
            default: begin
            end
        endcase
    end

    // ****************************************
    // Accumulator and memory write
    // ****************************************
    always_ff @(posedge i_ref_clk or posedge i_reset) begin
        if (i_reset) begin
            acc_r <= alx_pkg::ALX_ACC_RST;
            we_r <= 1'b0;
            waddr_r <= ALX_ZERO;
            wdata_r <= ALX_ZERO;
        end else if (i_clk_en) begin
            we_r <= go && to_mem;
            if (go && to_mem) begin
                waddr_r <= i_mem_addr;
                wdata_r <= res;
            end
            if (go && to_acc) begin
                acc_r <= res;
            end
        end
    end

    // ****************************************
    // Status flags
    // ****************************************
    // Flags outside the chosen update set hold their value
    always_ff @(posedge i_ref_clk or posedge i_reset) begin
        if (i_reset) begin
            ov_r <= 1'b0;
            z_r <= 1'b0;
            ac_r <= 1'b0;
            c_r <= 1'b0;
        end else if (go) begin
            if (upd_arith) begin
                ov_r <= add_res.ov;
                ac_r <= add_res.ac;
                c_r <= add_res.c;
            end
            if (upd_arith || upd_z) begin
                z_r <= (res == ALX_ZERO);
            end
            if (i_op == alx_pkg::ALX_OP_DAA) begin
                c_r <= daa_c;
            end
        end
    end

    // ****************************************
    // Watchdog, power-down and time-out
    // ****************************************
    always_ff @(posedge i_ref_clk or posedge i_reset) begin
        if (i_reset) begin
            wdt_r <= '0;
            pdf_r <= 1'b0;
            to_r <= 1'b0;
            pre1_r <= 1'b0;
            pre2_r <= 1'b0;
            halted_r <= 1'b0;
        end else if (i_clk_en) begin
            if (i_wdt_tick) begin
                wdt_r <= wdt_r + 1'b1;
                if (&wdt_r) begin
                    to_r <= 1'b1;
                    halted_r <= 1'b0;
                end
            end
            if (halted_r && i_wake) begin
                halted_r <= 1'b0;
            end
            if (go && i_op == alx_pkg::ALX_OP_WDT_CLR) begin
                wdt_r <= '0;
                pdf_r <= 1'b0;
                to_r <= 1'b0;
                pre1_r <= 1'b0;
                pre2_r <= 1'b0;
            end
            if (go && (i_op == alx_pkg::ALX_OP_WDT_PRE1 || i_op == alx_pkg::ALX_OP_WDT_PRE2)) begin
                // Clear only once the other half has been seen
                if ((i_op == alx_pkg::ALX_OP_WDT_PRE1 && pre2_r) ||
                    (i_op == alx_pkg::ALX_OP_WDT_PRE2 && pre1_r)) begin
                    wdt_r <= '0;
                    pdf_r <= 1'b0;
                    to_r <= 1'b0;
                    pre1_r <= 1'b0;
                    pre2_r <= 1'b0;
                end else if (i_op == alx_pkg::ALX_OP_WDT_PRE1) begin
                    pre1_r <= 1'b1;
                end else begin
                    pre2_r <= 1'b1;
                end
            end
            if (go && i_op == alx_pkg::ALX_OP_HALT) begin
                wdt_r <= '0;
                pdf_r <= 1'b1;
                to_r <= 1'b0;
                halted_r <= 1'b1;
            end
            // A wrap in the same cycle as a clear still reports the time-out
            if (i_wdt_tick && (&wdt_r)) begin
                to_r <= 1'b1;
            end
        end
    end

    // ****************************************
    // Program counter and return stack
    // ****************************************
    // Stack wraps when full, as a small hardware stack does
    always_ff @(posedge i_ref_clk or posedge i_reset) begin
        if (i_reset) begin
            pc_r <= alx_pkg::ALX_PC_RST;
            sp_r <= 3'd0;
            full_r <= 1'b0;
            ovf_r <= 1'b0;
            stall_r <= 2'd0;
            for (int k = 0; k < STACK_DEPTH; k++) begin
                stack_r[k] <= '0;
            end
        end else if (i_clk_en) begin
            if (stall_r != 2'd0) begin
                stall_r <= stall_r - 2'd1;
            end
            if (go) begin
                unique case (i_op)
                    alx_pkg::ALX_OP_CALL: begin
                        stack_r[sp_r] <= pc_r + alx_pkg::ALX_PC_STEP;
                        pc_r <= i_target;
                        // Overflow only once a push lands on a live entry
                        if (full_r) begin
                            ovf_r <= 1'b1;
                        end
                        if (sp_r == 3'(STACK_DEPTH - 1)) begin
                            sp_r <= 3'd0;
                            full_r <= 1'b1;
                        end else begin
                            sp_r <= sp_r + 3'd1;
                        end
                        stall_r <= 2'd1;
                    end
                    alx_pkg::ALX_OP_JMP: begin
                        pc_r <= i_target;
                        stall_r <= 2'd1;
                    end
                    default: begin
                        pc_r <= pc_r + alx_pkg::ALX_PC_STEP;
                        if (to_mem && i_mem_addr == alx_pkg::ALX_PCL_ADDR) begin
                            pc_r <= {pc_r[PC_W-1:8], res};
                            stall_r <= 2'd1;
                        end
                    end
                endcase
            end
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    assign o_busy = stall_r != 2'd0 || halted_r;
    assign o_mem_we = we_r;
    assign o_mem_addr = waddr_r;
    assign o_mem_wdata = wdata_r;
    assign o_accumulator_reg = acc_r;
    assign o_pc = pc_r;
    assign o_signed_overflow_flag = ov_r;
    assign o_zero_flag = z_r;
    assign o_nibble_carry_flag = ac_r;
    assign o_carry_flag = c_r;
    assign o_powerdown_flag = pdf_r;
    assign o_watchdog_timeout_flag = to_r;
    assign o_watchdog_counter = wdt_r;
    assign o_halted = halted_r;
    assign o_stack_overflow = ovf_r;

endmodule

/* verilog/alx_pkg.sv */
package alx_pkg;
    // Operation select codes for the execution datapath
    typedef enum logic [4:0] {
        ALX_OP_NONE,
        ALX_OP_ADC_A,
        ALX_OP_ADC_M,
        ALX_OP_ADD_A,
        ALX_OP_ADD_AX,
        ALX_OP_ADD_M,
        ALX_OP_AND_A,
        ALX_OP_AND_AX,
        ALX_OP_AND_M,
        ALX_OP_CALL,
        ALX_OP_CLR_M,
        ALX_OP_CLR_BIT,
        ALX_OP_WDT_CLR,
        ALX_OP_WDT_PRE1,
        ALX_OP_WDT_PRE2,
        ALX_OP_CPL_M,
        ALX_OP_CPL_A,
        ALX_OP_DAA,
        ALX_OP_DEC_M,
        ALX_OP_DEC_A,
        ALX_OP_HALT,
        ALX_OP_INC_M,
        ALX_OP_INC_A,
        ALX_OP_JMP
    } alx_op_t;

    localparam int ALX_DATA_W = 8;
    localparam int ALX_PC_W = 12;
    localparam int ALX_WDT_W = 8;
    localparam int ALX_STACK_DEPTH = 6;
    localparam int ALX_SYS_PER_INSTR = 4;
    localparam logic [7:0] ALX_ACC_RST = 8'h00;
    localparam logic [11:0] ALX_PC_RST = 12'h000;
    localparam logic [3:0] ALX_BCD_LIMIT = 4'h9;
    localparam logic [3:0] ALX_BCD_ADJ = 4'h6;
    localparam logic [7:0] ALX_ZERO_BYTE = 8'h00;
    localparam logic [7:0] ALX_ONE_BYTE = 8'h01;
    localparam logic [11:0] ALX_PC_STEP = 12'h001;
    localparam logic [7:0] ALX_PCL_ADDR = 8'h06;
endpackage
